// ===== verilog/fieldbus_pkg.sv
// Shared constants and types for the fieldbus slave diagnostic responder.
// Assumes a single clock domain shared by both link ends.
package fieldbus_pkg;
  // ----------------------------------------
  // Link frame kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    kind_prm,
    kind_cfg,
    kind_diag,
    kind_data
  } kind_t;

  // Service access points carried in parameter, config and diagnostic requests
  localparam logic [7:0] sap_diag = 8'd60;
  localparam logic [7:0] sap_prm = 8'd61;
  localparam logic [7:0] sap_cfg = 8'd62;

  // ----------------------------------------
  // Diagnostic block layout
  // ----------------------------------------
  localparam logic [3:0] diag_len_std = 4'd6;
  localparam logic [3:0] diag_len_ext = 4'd11;
  localparam logic [5:0] ext_block_len = 6'd5;
  localparam int status1_ext_bit = 3;
  localparam int status3_ovf_bit = 7;
  localparam int user_req_bit = 7;

  // ----------------------------------------
  // Wishbone register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] reg_user_diag = 8'h00;
  localparam logic [7:0] reg_control = 8'h04;
  localparam logic [7:0] reg_status = 8'h08;
  localparam logic [7:0] reg_input_data = 8'h0c;
  localparam logic [7:0] reg_output_data = 8'h10;
  localparam int ctrl_ovf_bit = 8;
  localparam logic [31:0] unmapped_value = 32'h00000000;

  // Reset values
  localparam logic [7:0] user_diag_reset = 8'h00;
  localparam logic [7:0] error_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
endpackage

// ===== verilog/fieldbus_link_if.sv
// Frame-level link between the bus master end and the slave end.
// Assumes both ends share clk; one request frame is a single-cycle pulse.
`timescale 1ns/1ps
interface fieldbus_link_if
  import fieldbus_pkg::*;
  (input wire logic clk);
  logic req_valid;
  kind_t req_kind;
  logic [7:0] req_sap;
  logic req_high_prio;
  logic [7:0] req_master_addr;
  logic [7:0] req_data;
  logic busy;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;
  logic rsp_high_prio;
  logic no_data_acknowledge;

  modport master (
    output req_valid, req_kind, req_sap, req_high_prio, req_master_addr, req_data,
    input busy, rsp_valid, rsp_data, rsp_last, rsp_high_prio, no_data_acknowledge
  );
  modport slave (
    input req_valid, req_kind, req_sap, req_high_prio, req_master_addr, req_data,
    output busy, rsp_valid, rsp_data, rsp_last, rsp_high_prio, no_data_acknowledge
  );
endinterface

// ===== verilog/diag_slave.sv
// Slave end: answers init frames, builds the diagnostic block, exchanges data.
// Assumes a classic Wishbone master on the user side and the link interface.
`timescale 1ns/1ps

// Summary of operation
// - Status octet 3 zero, bit7 overflow
// - Octet 4 carries parameterising master address
// - Octets 5-6 carry fixed ident number
// - Extended octets written only by slave
// - Header bits 0-5 give block length
// - Header bits 6-7 always zero
// - Octet 8 holds current error number
// - Octet 9 mirrors user diagnostic byte
// - Last two octets give firmware version
// - Parameters acked empty, then config, diagnostics
// - Six bytes normally, eleven when faulted
// - Fault at init blocks data exchange
// - Master sends output data high priority
// - Input returned low, high on error or user request
// - High priority persists until fault cleared
// - High priority prompts full diagnostic read
// - Master resumes exchange after diagnostics
// - Application posts value plus request bit
// - Slave clears request bit after delivery
// - Status octet 1 bit3 flags extended entry
module diag_slave
  import fieldbus_pkg::*;
  #(
  parameter logic [15:0] ident_number = 16'h1234, // Arbitrary value
  parameter logic [7:0] fw_major = 8'd1,
  parameter logic [7:0] fw_minor = 8'd0,
  parameter logic [7:0] cfg_byte = 8'h00
  ) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  fieldbus_link_if.slave link
  );

  // ----------------------------------------
  // State and storage
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_wait_prm,
    st_wait_cfg,
    st_wait_diag,
    st_exchange
  } slave_state_t;

  slave_state_t state;
  logic [7:0] user_diag;
  logic [7:0] error_num;
  logic ext_overflow;
  logic [7:0] master_addr;
  logic [7:0] input_data;
  logic [7:0] output_data;
  logic [3:0] tx_idx;
  logic [3:0] tx_len;
  kind_t tx_kind;
  logic tx_busy;
  logic fault;
  logic wb_hit;
  logic wb_wr;
  logic deliver_done;

  assign fault = (error_num != 8'h00) || user_diag[user_req_bit];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write lands at the edge where the master sees ack, never earlier
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  // User request is delivered when the last byte of a full block leaves
  assign deliver_done = tx_busy && tx_kind == kind_diag && tx_idx == tx_len - 4'd1
    && tx_len == diag_len_ext;

  // Byte of the diagnostic block at a given index
  function automatic logic [7:0] diag_byte(input logic [3:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      4'd0: b = {4'h0, fault, 3'b000};
      4'd1: b = 8'h00;
      4'd2: b = {ext_overflow, 7'b0000000};
      4'd3: b = master_addr;
      4'd4: b = ident_number[15:8];
      4'd5: b = ident_number[7:0];
      4'd6: b = {2'b00, ext_block_len};
      4'd7: b = error_num;
      4'd8: b = user_diag;
      4'd9: b = fw_major;
      4'd10: b = fw_minor;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // One wait state: ack follows the request by one edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // Read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= unmapped_value;
    end else if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        reg_user_diag: wb_dat_o <= {24'h0, user_diag};
        reg_control: wb_dat_o <= {23'h0, ext_overflow, error_num};
        reg_status: wb_dat_o <= {16'h0, master_addr, 5'h0, fault, state};
        reg_input_data: wb_dat_o <= {24'h0, input_data};
        reg_output_data: wb_dat_o <= {24'h0, output_data};
        default: wb_dat_o <= unmapped_value;
      endcase
    end
  end

  // User diagnostic byte; a software set beats the delivery clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_diag <= user_diag_reset;
    end else if (wb_wr && wb_adr_i == reg_user_diag) begin
      user_diag <= wb_dat_i[7:0];
    end else if (deliver_done) begin
      user_diag[user_req_bit] <= 1'b0;
    end
  end

  // Error number and overflow flag, owned by this end only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_num <= error_reset;
      ext_overflow <= 1'b0;
    end else if (wb_wr && wb_adr_i == reg_control) begin
      error_num <= wb_dat_i[7:0];
      if (wb_sel_i[1]) begin
        ext_overflow <= wb_dat_i[ctrl_ovf_bit];
      end
    end
  end

  // Input data that the slave returns each cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_data <= data_reset;
    end else if (wb_wr && wb_adr_i == reg_input_data) begin
      input_data <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------
  // Link request handling
  // ----------------------------------------
  // Sequence state; a faulted diagnostic answer keeps the link down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= st_wait_prm;
    end else if (link.req_valid && !tx_busy) begin
      case (link.req_kind)
        kind_prm: state <= st_wait_cfg;
        kind_cfg: begin
          if (state == st_wait_cfg) begin
            state <= st_wait_diag;
          end
        end
        kind_diag: begin
          if (state == st_wait_diag && !fault) begin
            state <= st_exchange;
          end
        end
        default: state <= state;
      endcase
    end
  end

  // Parameterising master address and received output data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_addr <= 8'h00;
      output_data <= data_reset;
    end else if (link.req_valid && !tx_busy) begin
      if (link.req_kind == kind_prm) begin
        master_addr <= link.req_master_addr;
      end
      if (link.req_kind == kind_data && state == st_exchange) begin
        output_data <= link.req_data;
      end
    end
  end

  // Response stream: length fixed when the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_busy <= 1'b0;
      tx_idx <= 4'd0;
      tx_len <= 4'd0;
      tx_kind <= kind_prm;
    end else if (tx_busy) begin
      tx_idx <= tx_idx + 4'd1;
      if (tx_idx == tx_len - 4'd1) begin
        tx_busy <= 1'b0;
      end
    end else if (link.req_valid) begin
      tx_idx <= 4'd0;
      tx_kind <= link.req_kind;
      case (link.req_kind)
        kind_cfg: begin
          tx_busy <= 1'b1;
          tx_len <= 4'd1;
        end
        kind_diag: begin
          tx_busy <= 1'b1;
          tx_len <= fault ? diag_len_ext : diag_len_std;
        end
        kind_data: begin
          tx_busy <= (state == st_exchange);
          tx_len <= 4'd1;
        end
        default: tx_busy <= 1'b0;
      endcase
    end
  end

  // Empty acknowledge for parameters and for data before exchange
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.no_data_acknowledge <= 1'b0;
    end else begin
      link.no_data_acknowledge <= link.req_valid && !tx_busy && (link.req_kind == kind_prm
        || (link.req_kind == kind_data && state != st_exchange));
    end
  end

  // Output byte, valid, last and priority from flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.rsp_valid <= 1'b0;
      link.rsp_data <= 8'h00;
      link.rsp_last <= 1'b0;
      link.rsp_high_prio <= 1'b0;
    end else begin
      link.rsp_valid <= tx_busy;
      link.rsp_last <= tx_busy && tx_idx == tx_len - 4'd1;
      case (tx_kind)
        kind_diag: link.rsp_data <= diag_byte(tx_idx);
        kind_cfg: link.rsp_data <= cfg_byte;
        default: link.rsp_data <= input_data;
      endcase
      // High on every data answer until the fault is cleared
      link.rsp_high_prio <= tx_busy && tx_kind == kind_data && fault;
    end
  end

  assign link.busy = tx_busy;
endmodule

// ===== verilog/diag_master.sv
// Master end: runs the init sequence, cyclic exchange, diagnostic fetch.
// Assumes the slave end on the same clock through the link interface.
`timescale 1ns/1ps
module diag_master
  import fieldbus_pkg::*;
  (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic cycle_i,
  input wire logic [7:0] own_addr_i,
  input wire logic [7:0] out_data_i,
  output logic link_up_o,
  output logic init_fault_o,
  output logic [7:0] in_data_o,
  output logic [7:0] diag_error_o,
  output logic [7:0] diag_user_o,
  fieldbus_link_if.master link
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_send,
    st_wait,
    st_run
  } master_state_t;

  master_state_t state;
  kind_t kind;
  logic [3:0] rx_count;
  logic in_init;
  logic done;
  logic high_seen;

  assign done = link.no_data_acknowledge || (link.rsp_valid && link.rsp_last);

  // Request pulse with its fields
  always_comb begin
    link.req_valid = (state == st_send) && !link.busy;
    link.req_kind = kind;
    link.req_master_addr = own_addr_i;
    link.req_data = out_data_i;
    link.req_high_prio = 1'b1;
    case (kind)
      kind_prm: link.req_sap = sap_prm;
      kind_cfg: link.req_sap = sap_cfg;
      kind_diag: link.req_sap = sap_diag;
      default: link.req_sap = 8'h00;
    endcase
  end

  // Frame sequence; next frame chosen when the answer completes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= st_idle;
      kind <= kind_prm;
      in_init <= 1'b0;
      link_up_o <= 1'b0;
      init_fault_o <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (start_i) begin
            state <= st_send;
            kind <= kind_prm;
            in_init <= 1'b1;
            init_fault_o <= 1'b0;
          end
        end
        st_send: begin
          if (!link.busy) begin
            state <= st_wait;
          end
        end
        st_wait: begin
          if (done) begin
            case (kind)
              kind_prm: begin
                kind <= kind_cfg;
                state <= st_send;
              end
              kind_cfg: begin
                kind <= kind_diag;
                state <= st_send;
              end
              kind_diag: begin
                if (in_init && rx_count + 4'd1 == diag_len_ext) begin
                  state <= st_idle;
                  init_fault_o <= 1'b1;
                end else begin
                  state <= st_run;
                  link_up_o <= 1'b1;
                end
                in_init <= 1'b0;
              end
              default: begin
                if (high_seen || (link.rsp_valid && link.rsp_high_prio)) begin
                  kind <= kind_diag;
                  state <= st_send;
                end else begin
                  state <= st_run;
                end
              end
            endcase
          end
        end
        st_run: begin
          if (cycle_i) begin
            kind <= kind_data;
            state <= st_send;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // ----------------------------------------
  // Answer capture
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_count <= 4'd0;
      high_seen <= 1'b0;
      in_data_o <= 8'h00;
      diag_error_o <= 8'h00;
      diag_user_o <= 8'h00;
    end else if (state == st_send) begin
      rx_count <= 4'd0;
      high_seen <= 1'b0;
    end else if (link.rsp_valid) begin
      rx_count <= rx_count + 4'd1;
      high_seen <= high_seen || link.rsp_high_prio;
      if (kind == kind_data) begin
        in_data_o <= link.rsp_data;
      end else if (kind == kind_diag && rx_count == 4'd7) begin
        diag_error_o <= link.rsp_data;
      end else if (kind == kind_diag && rx_count == 4'd8) begin
        diag_user_o <= link.rsp_data;
      end
    end
  end
endmodule

// ===== sim/fieldbus_link_chk.sv
// Checker for the link that joins the master end to the slave end.
// Assumes one clock and the ident and version values set on the slave.
`timescale 1ns/1ps
module fieldbus_link_chk
  import fieldbus_pkg::*;
  #(
  parameter logic [15:0] ident_number = 16'h1234, // Arbitrary value
  parameter logic [7:0] fw_major = 8'd1,
  parameter logic [7:0] fw_minor = 8'd0
  ) (
  input wire logic clk,
  input wire logic rst_i,
  input wire logic req_valid,
  input wire kind_t req_kind,
  input wire logic [7:0] req_sap,
  input wire logic req_high_prio,
  input wire logic [7:0] req_master_addr,
  input wire logic busy,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_high_prio,
  input wire logic no_data_acknowledge
  );
  default clocking @(posedge clk); endclocking
  default disable iff (rst_i);
  wire take = req_valid && !busy;
  logic [3:0] idx;
  logic in_diag;
  logic ext;
  logic [7:0] maddr;
  // Byte position in the answer, restarted by every taken request
  always_ff @(posedge clk) begin
    if (rst_i || take) begin
      idx <= 4'h0;
    end else if (rsp_valid) begin
      idx <= idx + 4'h1;
    end
  end
  // Answer kind, fault flag of byte 1, and the parameterising address
  always_ff @(posedge clk) begin
    if (rst_i) begin
      in_diag <= 1'b0;
      ext <= 1'b0;
      maddr <= 8'h00;
    end else begin
      if (take) in_diag <= (req_kind == kind_diag);
      if (take && req_kind == kind_prm) maddr <= req_master_addr;
      if (rsp_valid && idx == 4'h0) ext <= rsp_data[status1_ext_bit];
    end
  end
  // ----------------------------------------
  // Link properties
  // ----------------------------------------
  prm_ack_a: assert property (take && req_kind == kind_prm |=> no_data_acknowledge)
    else $error("parameters not acknowledged");
  sap_map_a: assert property (req_valid && req_kind != kind_data |-> req_sap ==
    (req_kind == kind_prm ? sap_prm : req_kind == kind_cfg ? sap_cfg : sap_diag)) else $error("wrong access point");
  cfg_answer_a: assert property (take && req_kind == kind_cfg |=> busy ##1 rsp_valid && rsp_last)
    else $error("config answer wrong");
  diag_len_a: assert property (rsp_valid && rsp_last && in_diag |-> idx == (ext ? 4'd10 : 4'd5))
    else $error("diag length does not match fault flag");
  status3_a: assert property (rsp_valid && in_diag && idx == 4'd2 |-> rsp_data[6:0] == 7'h00)
    else $error("status octet 3 reserved bits set");
  master_addr_a: assert property (rsp_valid && in_diag && idx == 4'd3 |-> rsp_data == maddr)
    else $error("master address wrong");
  ident_a: assert property (rsp_valid && in_diag && idx == 4'd4 |-> rsp_data == ident_number[15:8]
    ##1 rsp_valid && rsp_data == ident_number[7:0]) else $error("ident wrong");
  header_a: assert property (rsp_valid && in_diag && idx == 4'd6 |-> rsp_data == {2'b00, ext_block_len})
    else $error("header byte wrong");
  fw_version_a: assert property (rsp_valid && in_diag && idx == 4'd9 |-> rsp_data == fw_major
    ##1 rsp_valid && rsp_last && rsp_data == fw_minor) else $error("version bytes wrong");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:12] !busy)
    else $error("answer too long");
  data_prio_a: assert property (req_valid && req_kind == kind_data |-> req_high_prio)
    else $error("data request low priority");
  hp_fetch_a: assert property (rsp_valid && rsp_high_prio && !in_diag |-> ##[1:8] take && req_kind == kind_diag)
    else $error("no diag fetch after high priority");
endmodule

// ===== sim/tb_fieldbus_slave_diag_responder.sv
// Bench joining both ends; drives Wishbone and the master's user inputs.
// Assumes the package, interface, both ends and the checker compiled first.
`timescale 1ns/1ps
module tb_fieldbus_slave_diag_responder;
  import fieldbus_pkg::*;
  localparam logic [15:0] ident = 16'h1234; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic start_i = 1'b0;
  logic cycle_i = 1'b0;
  logic [7:0] own_addr_i = 8'h00;
  logic [7:0] out_data_i = 8'h00;
  logic link_up_o;
  logic init_fault_o;
  logic [7:0] in_data_o;
  logic [7:0] diag_error_o;
  logic [7:0] diag_user_o;
  int err_count = 0;
  int cmp_count = 0;
  kind_t last_kind = kind_prm;
  logic [7:0] diag_b [0:15];
  logic [3:0] rsp_cnt = 4'h0;
  logic [3:0] diag_len;
  logic data_hp;
  logic [31:0] rd;
  logic [7:0] addr;
  logic [6:0] u;

  initial forever #20 clk_i = ~clk_i;

  fieldbus_link_if link (.clk(clk_i));
  diag_slave #(.ident_number(ident)) u_diag_slave (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(link.slave));
  diag_master u_diag_master (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .cycle_i(cycle_i),
    .own_addr_i(own_addr_i), .out_data_i(out_data_i), .link_up_o(link_up_o), .init_fault_o(init_fault_o),
    .in_data_o(in_data_o), .diag_error_o(diag_error_o), .diag_user_o(diag_user_o), .link(link.master));
  fieldbus_link_chk #(.ident_number(ident)) u_fieldbus_link_chk (.clk(clk_i), .rst_i(rst_i),
    .req_valid(link.req_valid), .req_kind(link.req_kind), .req_sap(link.req_sap),
    .req_high_prio(link.req_high_prio), .req_master_addr(link.req_master_addr), .busy(link.busy),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .rsp_last(link.rsp_last),
    .rsp_high_prio(link.rsp_high_prio), .no_data_acknowledge(link.no_data_acknowledge));

  // Response monitor: diag bytes, their count, data frame priority
  always @(posedge clk_i) begin
    if (link.req_valid && !link.busy) begin
      last_kind <= link.req_kind;
      rsp_cnt <= 4'h0;
    end else if (link.rsp_valid) begin
      rsp_cnt <= rsp_cnt + 4'h1;
      if (last_kind == kind_diag) diag_b[rsp_cnt] <= link.rsp_data;
      if (last_kind == kind_diag && link.rsp_last) diag_len <= rsp_cnt + 4'h1;
      if (last_kind == kind_data) data_hp <= link.rsp_high_prio;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Expected diagnostic block length for a given fault state
  function automatic logic [31:0] exp_len(input logic flt);
    return flt ? 32'(diag_len_ext) : 32'(diag_len_std);
  endfunction
  task automatic fail_out(input string name);
    err_count++;
    $display("[FAIL] %s expected done seen timeout", name);
    final_report();
  endtask
  // Classic single cycle; the answer's latency is never assumed
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) fail_out("wb ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Pulse start or cycle, then wait for a quiet link
  task automatic pulse(input logic cyc);
    int q;
    int n;
    @(posedge clk_i);
    if (cyc) cycle_i <= 1'b1;
    else start_i <= 1'b1;
    @(posedge clk_i);
    cycle_i <= 1'b0;
    start_i <= 1'b0;
    q = 0;
    for (n = 0; n < 200 && q < 6; n++) begin
      @(posedge clk_i);
      q = (link.req_valid || link.busy || link.rsp_valid) ? 0 : q + 1;
    end
    if (q < 6) fail_out("link idle");
  endtask
  // One data exchange with random bytes both ways
  task automatic exchange(input logic hp);
    logic [7:0] v;
    v = 8'($urandom);
    wb(1'b1, reg_input_data, {24'h0, v}, 4'h1);
    out_data_i <= 8'($urandom);
    data_hp = 1'bx;
    pulse(1'b1);
    chk("input byte", {24'h0, v}, {24'h0, in_data_o});
    chk("priority", {31'h0, hp}, {31'h0, data_hp});
    wb(1'b0, reg_output_data, 32'h0, 4'hf);
    chk("output byte", {24'h0, out_data_i}, rd);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h9f9ee07b));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, reg_user_diag, 32'h0, 4'hf);
    chk("user reset", {24'h0, user_diag_reset}, rd);
    wb(1'b1, 8'h20, 32'hffffffff, 4'hf);
    wb(1'b0, 8'h20, 32'h0, 4'hf);
    chk("unmapped", unmapped_value, rd);
    $display("test reset done");
    addr = 8'($urandom_range(1, 125));
    own_addr_i <= addr;
    pulse(1'b0);
    chk("link up", 32'h1, {31'h0, link_up_o});
    chk("diag len", exp_len(1'b0), {28'h0, diag_len});
    wb(1'b0, reg_status, 32'h0, 4'hf);
    chk("status", {16'h0, addr, 8'h03}, rd & 32'hff07);
    repeat (6) exchange(1'b0);
    $display("test clean start done");
    wb(1'b1, reg_control, 32'h107, 4'h3);
    exchange(1'b1);
    chk("diag len", exp_len(1'b1), {28'h0, diag_len});
    chk("error num", 32'h7, {24'h0, diag_error_o});
    chk("status3", 32'h80, {24'h0, diag_b[2]});
    chk("ext flag", 32'h1, {31'h0, diag_b[0][status1_ext_bit]});
    exchange(1'b1);
    wb(1'b1, reg_control, 32'h0, 4'h3);
    exchange(1'b0);
    $display("test error number done");
    u = 7'($urandom);
    wb(1'b1, reg_user_diag, {24'h0, 1'b1, u}, 4'h1);
    exchange(1'b1);
    chk("user in diag", {24'h0, 1'b1, u}, {24'h0, diag_user_o});
    wb(1'b0, reg_user_diag, 32'h0, 4'hf);
    chk("user cleared", {24'h0, 1'b0, u}, rd);
    exchange(1'b0);
    $display("test user diag done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, reg_control, 32'h8, 4'h1);
    pulse(1'b0);
    chk("init fault", 32'h1, {31'h0, init_fault_o});
    chk("link down", 32'h0, {31'h0, link_up_o});
    chk("diag len", exp_len(1'b1), {28'h0, diag_len});
    wb(1'b0, reg_status, 32'h0, 4'hf);
    chk("state", 32'h2, rd & 32'h3);
    $display("test init fault done");
    final_report();
  end
endmodule
